//--- core/frasc_pkg.sv
package frasc_pkg;
  // Widths
  localparam int ADDR_W = 14;
  localparam int PWS_W = 3;
  localparam int DEP_W = 3;
  localparam int PADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_ADDR = 12'h008;
  // Control field positions and reset value
  localparam int CTRL_PWS_LSB = 0;
  localparam int CTRL_DEP_LSB = 3;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // Status field positions
  localparam int STAT_EMPTY = 0;
  localparam int STAT_HALF = 1;
  localparam int STAT_FULL = 2;
  localparam int STAT_BUSY = 3;
  localparam int STAT_OCC_LSB = 16;
  // Address register field positions
  localparam int ADDR_WR_LSB = 0;
  localparam int ADDR_RD_LSB = 16;
  // Counter values
  localparam logic [13:0] ADDR_ALL = 14'h3fff;
  localparam logic [13:0] ONE = 14'h0001;
  localparam logic [1:0] TMR_ZERO = 2'h0;
  localparam logic [1:0] TMR_ONE = 2'h1;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b100
  } frasc_state_e;
endpackage : frasc_pkg

//--- core/frasc_top.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RULE1) Three 14-bit counters: write, read, occupancy
// (RULE2) Occupancy up on write, down on read
// (RULE3) Arrival order; ties by half-full flag
// (RULE4) Burst input denies other direction
// (RULE5) Both bursts: normal priority applies
// (RULE6) Strobe lasts low select bits plus one
// (RULE7) Select constant low in modes 0-3
// (RULE8) Depth code halves 16K down to 128
// (RULE9) Unused upper address bits left undriven
// (RULE10) Fourteen three-state address outputs
// (RULE11) Reset clears counters, sets empty only
// (RULE12) Reset values of strobes, accepts, latches
// (RULE13) Burst read forces write accept high
// (RULE14) Burst write forces read accept high
// (RULE15) Write accept low one cycle per grant
// (RULE16) Read accept returns at select rise
// (RULE17) Inactive part: undriven, no new grants
// (RULE18) Output latch strobe, high in modes 0-3
// (RULE19) Input latch strobe and drive signal
// (RULE20) Full flag set and cleared on falling edge
// (RULE21) Half flag like full at half depth
// (RULE22) Empty flag set and cleared on falling edge
// (RULE23) Accepts held low while full or empty
// (RULE24) One RAM operation at a time
module frasc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requesting logic
  input wire logic write_request_n,
  input wire logic read_request_n,
  input wire logic burst_write_n,
  input wire logic burst_read_n,
  input wire logic part_activate_n,
  output logic write_accept,
  output logic read_accept,
  // Status flags
  output logic empty,
  output logic half_full,
  output logic full,
  // RAM interface
  output logic [13:0] ram_address_out,
  output logic [13:0] ram_address_oe,
  output logic ram_write_n,
  output logic ram_write_oe,
  output logic ram_select_n,
  output logic ram_select_oe,
  // External data latches
  output logic input_latch_strobe,
  output logic input_latch_drive_n,
  output logic output_latch_strobe
);

  // Address mask for a depth code
  function automatic logic [13:0] depth_mask(input logic [2:0] code);
    depth_mask = frasc_pkg::ADDR_ALL >> code;
  endfunction : depth_mask

  // Masked address increment
  function automatic logic [13:0] next_addr(input logic [13:0] a, input logic [13:0] m);
    next_addr = (a + frasc_pkg::ONE) & m;
  endfunction : next_addr

  frasc_pkg::frasc_state_e st_q, st_d;
  logic [2:0] pws_q, dep_q;
  logic [13:0] wr_addr_q, rd_addr_q, occ_q;
  logic [1:0] tmr_q, len_q;
  logic empty_q, half_q, full_q;
  logic wacc_q, racc_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [13:0] addr_q, addr_oe_q;
  logic wr_n_q, sel_n_q, oe_q;
  logic in_stb_q, in_drv_n_q, out_stb_q;

  // Arbitration
  wire idle = (st_q == frasc_pkg::ST_IDLE);
  wire br = !burst_read_n;
  wire bw = !burst_write_n;
  wire only_br = br && !bw; // RULE5
  wire only_bw = bw && !br; // RULE5
  wire wr_ok = !write_request_n && !full_q;
  wire rd_ok = !read_request_n && !empty_q;
  wire pick_wr = wr_ok && !only_br && (!rd_ok || only_bw || !half_q); // RULE3 RULE4 RULE14
  wire pick_rd = rd_ok && !only_bw && !pick_wr; // RULE3 RULE4 RULE13
  wire may_grant = idle && !part_activate_n; // RULE17 RULE24
  wire grant_wr = may_grant && pick_wr;
  wire grant_rd = may_grant && pick_rd;
  wire op_done = !idle && (tmr_q == len_q); // RULE6
  wire wr_done = op_done && (st_q == frasc_pkg::ST_WR);
  wire rd_done = op_done && (st_q == frasc_pkg::ST_RD);
  wire [13:0] mask = depth_mask(dep_q); // RULE8
  wire [13:0] full_last = mask; // RULE20
  wire [13:0] half_last = mask >> 1; // RULE21

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      frasc_pkg::ST_IDLE: begin
        if (grant_wr) begin
          st_d = frasc_pkg::ST_WR;
        end else if (grant_rd) begin
          st_d = frasc_pkg::ST_RD;
        end
      end
      frasc_pkg::ST_WR: begin
        if (op_done) begin
          st_d = frasc_pkg::ST_IDLE;
        end
      end
      frasc_pkg::ST_RD: begin
        if (op_done) begin
          st_d = frasc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Strobe timing and counters
  wire [1:0] tmr_d = idle ? frasc_pkg::TMR_ZERO : tmr_q + frasc_pkg::TMR_ONE;
  wire [1:0] len_d = may_grant ? pws_q[1:0] : len_q; // RULE6
  wire [13:0] wr_addr_d = wr_done ? next_addr(wr_addr_q, mask) : wr_addr_q; // RULE1
  wire [13:0] rd_addr_d = rd_done ? next_addr(rd_addr_q, mask) : rd_addr_q; // RULE1
  wire [13:0] occ_d = wr_done ? occ_q + frasc_pkg::ONE :
                      rd_done ? occ_q - frasc_pkg::ONE : occ_q; // RULE2

  // Accept handshakes
  wire rd_hold = (st_q == frasc_pkg::ST_RD) && !op_done; // RULE16
  wire wacc_d = grant_wr ? 1'b0 : br ? 1'b1 : !full_q; // RULE15 RULE13 RULE23
  wire racc_d = (grant_rd || rd_hold) ? 1'b0 : bw ? 1'b1 : !empty_q; // RULE16 RULE14 RULE23

  // RAM side outputs
  wire busy_d = (st_d != frasc_pkg::ST_IDLE); // RULE24
  wire wr_d = (st_d == frasc_pkg::ST_WR);
  wire oe_d = !part_activate_n || busy_d; // RULE17
  wire sel_n_d = pws_q[2] ? !busy_d : 1'b0; // RULE7
  wire [13:0] addr_d = (st_d == frasc_pkg::ST_RD) ? rd_addr_q : wr_addr_q; // RULE12
  wire [13:0] addr_oe_d = oe_d ? mask : '0; // RULE9 RULE10
  wire out_stb_d = !pws_q[2] || !rd_done; // RULE18

  // APB decode
  wire setup = psel && !penable;
  wire hit_ctrl = (paddr == frasc_pkg::OFS_CTRL);
  wire hit_stat = (paddr == frasc_pkg::OFS_STATUS);
  wire hit_addr = (paddr == frasc_pkg::OFS_ADDR);
  wire mapped = hit_ctrl || hit_stat || hit_addr;
  wire ctrl_wr = psel && penable && pwrite && hit_ctrl;
  wire [31:0] ctrl_rd = {26'h0, dep_q, pws_q};
  wire [31:0] stat_rd = {2'h0, occ_q, 12'h0, !idle, full_q, half_q, empty_q};
  wire [31:0] addr_rd = {2'h0, rd_addr_q, 2'h0, wr_addr_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : hit_addr ? addr_rd : '0;

  // Bus registers and configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      pws_q <= frasc_pkg::CTRL_RST[frasc_pkg::CTRL_PWS_LSB +: frasc_pkg::PWS_W];
      dep_q <= frasc_pkg::CTRL_RST[frasc_pkg::CTRL_DEP_LSB +: frasc_pkg::DEP_W];
    end else begin
      pready_q <= 1'b1;
      if (setup) begin
        prdata_q <= pwrite ? '0 : rd_mux;
        pslverr_q <= !mapped;
      end
      if (ctrl_wr) begin
        pws_q <= pwdata[frasc_pkg::CTRL_PWS_LSB +: frasc_pkg::PWS_W];
        dep_q <= pwdata[frasc_pkg::CTRL_DEP_LSB +: frasc_pkg::DEP_W];
      end
    end
  end

  // Sequencer and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= frasc_pkg::ST_IDLE;
      tmr_q <= frasc_pkg::TMR_ZERO;
      len_q <= frasc_pkg::TMR_ZERO;
      wr_addr_q <= '0; // RULE11
      rd_addr_q <= '0; // RULE11
      occ_q <= '0; // RULE11
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      len_q <= len_d;
      wr_addr_q <= wr_addr_d;
      rd_addr_q <= rd_addr_d;
      occ_q <= occ_d;
    end
  end

  // Registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wacc_q <= 1'b1; // RULE12
      racc_q <= 1'b0; // RULE12
      wr_n_q <= 1'b1; // RULE12
      sel_n_q <= 1'b1; // RULE12
      oe_q <= 1'b0;
      addr_q <= '0;
      addr_oe_q <= '0;
      in_stb_q <= 1'b1; // RULE12
      in_drv_n_q <= 1'b1; // RULE12
      out_stb_q <= 1'b1; // RULE12
    end else begin
      wacc_q <= wacc_d;
      racc_q <= racc_d;
      wr_n_q <= !wr_d; // RULE6
      sel_n_q <= sel_n_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      addr_oe_q <= addr_oe_d;
      in_stb_q <= !wr_d; // RULE19
      in_drv_n_q <= !wr_d; // RULE19
      out_stb_q <= out_stb_d;
    end
  end

  // Status flags on the falling edge, set beats clear
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_q <= 1'b1; // RULE11
      half_q <= 1'b0; // RULE11
      full_q <= 1'b0; // RULE11
    end else begin
      if (!wacc_q && occ_q == full_last) begin
        full_q <= 1'b1; // RULE20
      end else if (!racc_q) begin
        full_q <= 1'b0; // RULE20
      end
      if (!wacc_q && occ_q == half_last) begin
        half_q <= 1'b1; // RULE21
      end else if (!racc_q) begin
        half_q <= 1'b0; // RULE21
      end
      if (!racc_q && occ_q == frasc_pkg::ONE) begin
        empty_q <= 1'b1; // RULE22
      end else if (!wacc_q) begin
        empty_q <= 1'b0; // RULE22
      end
    end
  end

  // Port drive
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign write_accept = wacc_q;
  assign read_accept = racc_q;
  assign empty = empty_q;
  assign half_full = half_q;
  assign full = full_q;
  assign ram_address_out = addr_q;
  assign ram_address_oe = addr_oe_q;
  assign ram_write_n = wr_n_q;
  assign ram_write_oe = oe_q;
  assign ram_select_n = sel_n_q;
  assign ram_select_oe = oe_q;
  assign input_latch_strobe = in_stb_q;
  assign input_latch_drive_n = in_drv_n_q;
  assign output_latch_strobe = out_stb_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wacc_one_cycle: assert property ( // RULE15
    $fell(wacc_q) |=> (wacc_q || $past(full_q))
  ) else $error("write accept held past one cycle");

  chk_occ_write_up: assert property ( // RULE2
    wr_done |=> occ_q == $past(occ_q) + frasc_pkg::ONE
  ) else $error("occupancy did not count up");

  chk_occ_read_down: assert property ( // RULE2
    rd_done |=> occ_q == $past(occ_q) - frasc_pkg::ONE
  ) else $error("occupancy did not count down");

  chk_strobe_four_long: assert property ( // RULE6
    ($fell(wr_n_q) && len_q == 2'h3) |-> !wr_n_q [*4] ##1 wr_n_q
  ) else $error("write strobe length wrong");

  chk_select_low_mode: assert property ( // RULE7
    !pws_q[2] |=> !sel_n_q
  ) else $error("select not low in short modes");

  chk_empty_blocks_rd: assert property ( // RULE23
    ($past(empty_q) && $past(burst_write_n) && idle) |-> !racc_q
  ) else $error("read accept high while empty");

  chk_full_blocks_wr: assert property ( // RULE23
    ($past(full_q) && $past(burst_read_n) && $past(st_q) == frasc_pkg::ST_IDLE) |-> !wacc_q
  ) else $error("write accept high while full");

  chk_inactive_hiz: assert property ( // RULE17
    (idle && $past(part_activate_n)) |-> (!oe_q && addr_oe_q == '0)
  ) else $error("RAM pins driven while inactive");

  chk_no_new_grant: assert property ( // RULE17
    (idle && part_activate_n) |=> idle
  ) else $error("grant while part inactive");

  chk_burst_wr_only: assert property ( // RULE4
    (idle && only_bw) |=> st_q != frasc_pkg::ST_RD
  ) else $error("read granted during burst write");

  chk_tie_priority: assert property ( // RULE3
    (may_grant && wr_ok && rd_ok && !only_br && !only_bw) |=>
      st_q == ($past(half_q) ? frasc_pkg::ST_RD : frasc_pkg::ST_WR)
  ) else $error("tie priority wrong");

  chk_addr_mask: assert property ( // RULE9
    oe_d |=> addr_oe_q == $past(mask)
  ) else $error("address enable mask wrong");

  chk_burst_rd_wacc: assert property ( // RULE13
    only_br |=> wacc_q
  ) else $error("write accept low during burst read");

  chk_burst_wr_racc: assert property ( // RULE14
    (only_bw && st_q != frasc_pkg::ST_RD) |=> racc_q
  ) else $error("read accept low during burst write");

  chk_read_accept_hold: assert property ( // RULE16
    (st_q == frasc_pkg::ST_RD && !op_done) |=> !racc_q
  ) else $error("read accept rose before strobe end");

  chk_out_latch_high: assert property ( // RULE18
    !pws_q[2] |=> out_stb_q
  ) else $error("output latch strobe low in short modes");

  chk_in_latch_write: assert property ( // RULE19
    $fell(in_stb_q) |-> st_q == frasc_pkg::ST_WR
  ) else $error("input latch strobe fell outside a write");

  chk_full_set: assert property ( // RULE20
    (!wacc_q && occ_q == full_last) |-> full_q
  ) else $error("full flag not set");

  chk_full_clear: assert property ( // RULE20
    (!racc_q && wacc_q) |-> !full_q
  ) else $error("full flag not cleared");

  chk_half_set: assert property ( // RULE21
    (!wacc_q && occ_q == half_last) |-> half_q
  ) else $error("half flag not set");

  chk_empty_set: assert property ( // RULE22
    (!racc_q && occ_q == frasc_pkg::ONE) |-> empty_q
  ) else $error("empty flag not set");

  chk_short_strobe: assert property ( // RULE6
    ($fell(wr_n_q) && len_q == frasc_pkg::TMR_ZERO) |=> wr_n_q
  ) else $error("single cycle strobe too long");

endmodule : frasc_top
`default_nettype wire

//--- tb/frasc_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module frasc_ram_model (
  // RAM pins
  input wire logic pclk,
  input wire logic [13:0] ram_address_out,
  input wire logic ram_write_n,
  input wire logic ram_write_oe,
  // Observation
  output logic [13:0] last_wr_addr,
  output logic [15:0] wr_count
);
  logic was_high = 1'b1;
  logic [13:0] addr_seen = 14'h0000;
  logic [15:0] strobes = 16'h0000;
  assign last_wr_addr = addr_seen;
  assign wr_count = strobes;
  // Store on a driven write strobe; count each strobe once
  always @(negedge pclk) begin
    if (ram_write_n === 1'b0 && ram_write_oe === 1'b1) begin
      addr_seen <= ram_address_out;
      if (was_high) begin
        strobes <= strobes + 16'h0001;
      end
    end
    was_high <= (ram_write_n !== 1'b0);
  end
endmodule : frasc_ram_model
`default_nettype wire

//--- tb/frasc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module frasc_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic write_request_n = 1'b1;
  logic read_request_n = 1'b1;
  logic burst_write_n = 1'b1;
  logic burst_read_n = 1'b1;
  logic part_activate_n = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, re, write_accept, read_accept, empty, half_full, full;
  logic [13:0] ram_address_out, ram_address_oe, last_wr_addr;
  logic ram_write_n, ram_write_oe, ram_select_n, ram_select_oe;
  logic input_latch_strobe, input_latch_drive_n, output_latch_strobe;
  logic [15:0] wr_count;
  logic [2:0] t;
  int miscompares = 0;
  int checked = 0;
  int wl, sl, al, ol, dl, n;
  // Clock at 10 MHz
  always #50 pclk = ~pclk;
  frasc_top i_frasc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_request_n(write_request_n), .read_request_n(read_request_n),
    .burst_write_n(burst_write_n), .burst_read_n(burst_read_n),
    .part_activate_n(part_activate_n), .write_accept(write_accept),
    .read_accept(read_accept), .empty(empty), .half_full(half_full), .full(full),
    .ram_address_out(ram_address_out), .ram_address_oe(ram_address_oe),
    .ram_write_n(ram_write_n), .ram_write_oe(ram_write_oe), .ram_select_n(ram_select_n),
    .ram_select_oe(ram_select_oe), .input_latch_strobe(input_latch_strobe),
    .input_latch_drive_n(input_latch_drive_n), .output_latch_strobe(output_latch_strobe));
  frasc_ram_model i_frasc_ram_model (.pclk(pclk), .ram_address_out(ram_address_out),
    .ram_write_n(ram_write_n), .ram_write_oe(ram_write_oe),
    .last_wr_addr(last_wr_addr), .wr_count(wr_count));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // APB transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One request, then low-cycle counts over an eight-cycle window
  task op(input logic dr);
    int i;
    @(posedge pclk);
    if (dr) read_request_n <= 1'b0;
    else write_request_n <= 1'b0;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while ((dr ? read_accept : write_accept) !== 1'b0 && i < 6);
    read_request_n <= 1'b1;
    write_request_n <= 1'b1;
    wl = 0;
    sl = 0;
    al = 0;
    ol = 0;
    dl = 0;
    for (i = 0; i < 8; i++) begin
      wl += int'(ram_write_n === 1'b0);
      sl += int'(ram_select_n === 1'b0);
      al += int'((dr ? read_accept : write_accept) === 1'b0);
      ol += int'(output_latch_strobe === 1'b0);
      dl += int'(input_latch_drive_n === 1'b0);
      @(posedge pclk);
    end
  endtask : op
  // Both requests together; t holds write_accept, read_accept, ram_write_n
  task both(input logic br, input logic bw);
    @(posedge pclk);
    burst_read_n <= br;
    burst_write_n <= bw;
    write_request_n <= 1'b0;
    read_request_n <= 1'b0;
    repeat (2) @(posedge pclk);
    t = {write_accept, read_accept, ram_write_n};
    write_request_n <= 1'b1;
    read_request_n <= 1'b1;
    repeat (8) @(posedge pclk);
    burst_read_n <= 1'b1;
    burst_write_n <= 1'b1;
  endtask : both
  // Values held during reset, then release
  task s_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({22'h0, write_accept, read_accept, empty, half_full, full, ram_write_n, ram_select_n,
      input_latch_strobe, input_latch_drive_n, output_latch_strobe}, 32'h29f);
    chk({16'h0, ram_address_oe, ram_write_oe, ram_select_oe}, 32'h0);
    presetn <= 1'b1;
  endtask : s_reset
  // Register access and an unmapped address
  task s_regs;
    apb(1'b1, frasc_pkg::OFS_CTRL, 32'h3f);
    apb(1'b0, frasc_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h3f);
    apb(1'b0, frasc_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, frasc_pkg::OFS_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, re}, 32'h1);
  endtask : s_regs
  // Every pulse width mode: one write and one read
  task s_modes;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, frasc_pkg::OFS_CTRL, 32'(m));
      n = (m % 4) + 1;
      op(1'b0);
      chk(32'(wl), 32'(n));
      chk(32'(dl), 32'(n));
      chk(32'(sl), 32'(m > 3 ? n : 8));
      chk({18'h0, last_wr_addr}, 32'(m));
      chk({16'h0, wr_count}, 32'(m + 1));
      op(1'b1);
      chk(32'(wl), 32'h0);
      chk(32'(sl), 32'(m > 3 ? n : 8));
      chk(32'(ol), 32'(m > 3 ? 1 : 0));
      chk({31'h0, empty}, 32'h1);
    end
  endtask : s_modes
  // Smallest depth: fill to full, refuse, drain to empty
  task s_fill;
    apb(1'b1, frasc_pkg::OFS_CTRL, 32'h38);
    repeat (2) @(posedge pclk);
    chk({18'h0, ram_address_oe}, 32'h7f);
    for (int k = 1; k <= 129; k++) begin
      op(1'b0);
      if (k == 63 || k == 64) chk({31'h0, half_full}, 32'(k == 64));
      if (k == 64) begin
        both(1'b1, 1'b1);
        chk({29'h0, t}, 32'h5);
      end
      if (k == 128 || k == 129) chk({31'h0, full}, 32'(k == 129));
    end
    op(1'b0);
    chk(32'(wl), 32'h0);
    chk(32'(al), 32'h8);
    apb(1'b0, frasc_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h00800006);
    op(1'b1);
    chk({31'h0, full}, 32'h0);
    chk(32'(al), 32'h1);
    both(1'b1, 1'b1);
    chk({29'h0, t}, 32'h2);
    for (int i = 0; i < 130 && empty !== 1'b1; i++) op(1'b1);
    chk({30'h0, half_full, empty}, 32'h1);
  endtask : s_fill
  // Ties with and without bursts
  task s_arb;
    op(1'b0);
    both(1'b1, 1'b1);
    chk({29'h0, t}, 32'h2);
    both(1'b0, 1'b1);
    chk({29'h0, t}, 32'h5);
    both(1'b1, 1'b0);
    chk({29'h0, t}, 32'h2);
    both(1'b0, 1'b0);
    chk({29'h0, t}, 32'h2);
  endtask : s_arb
  // Inactive part: pins released, no grant
  task s_part;
    part_activate_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({16'h0, ram_address_oe, ram_write_oe, ram_select_oe}, 32'h0);
    op(1'b0);
    chk(32'(wl), 32'h0);
    part_activate_n <= 1'b0;
  endtask : s_part
  // Counts and verdict
  task complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial begin
    s_reset();
    s_regs();
    s_modes();
    s_fill();
    s_arb();
    s_part();
    complete_run();
  end
endmodule : frasc_tb_top
`default_nettype wire
